/* hw/wake_timer_pkg.sv */
// Constants shared by the battery-mode wake timer and its timer core.
package wake_timer_pkg;

    // System clock and crystal time base.
    localparam int unsigned CLK_HZ = 40000000;
    localparam int unsigned XTAL_HZ = 32768;
    localparam int ACC_W = 26;
    localparam logic [25:0] ACC_STEP = 26'(XTAL_HZ);
    localparam logic [25:0] ACC_WRAP = 26'(CLK_HZ);

    // Count unit lengths in milliseconds and in crystal cycles.
    localparam longint unsigned UNIT_SHORT_MS = 2500;
    localparam longint unsigned UNIT_LONG_MS = 60000;
    localparam int UNIT_W = 21;
    localparam int unsigned UNIT_SHORT_TICKS =
        32'(XTAL_HZ * UNIT_SHORT_MS / 64'd1000);
    localparam int unsigned UNIT_LONG_TICKS =
        32'(XTAL_HZ * UNIT_LONG_MS / 64'd1000);

    // Crystal cycles from wake to processor start, at most three.
    localparam int unsigned START_XTAL_MAX = 3;
    localparam logic [1:0] START_TICKS = 2'h2;

    // Register byte offsets.
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_MODE_REQ = 5'h04;
    localparam logic [4:0] OFS_STATUS = 5'h08;
    localparam logic [4:0] OFS_MASK = 5'h0C;
    localparam logic [4:0] OFS_STATE = 5'h10;

    // Control register fields.
    localparam int CTRL_ARM = 0;
    localparam int CTRL_UNIT = 1;
    localparam int CTRL_CNT_LO = 2;
    localparam int CTRL_RUN = 5;
    localparam int CNT_W = 3;

    // Mode request fields.
    localparam int REQ_SLEEP = 0;
    localparam int REQ_DISPLAY = 1;

    // Status and mask fields.
    localparam int EV_W = 3;
    localparam int EV_TIMER = 0;
    localparam int EV_BUTTON = 1;
    localparam int EV_POWER = 2;
    localparam logic [2:0] EV_RESET = 3'h0;

    // Operating modes, one-hot.
    typedef enum logic [4:0] {
        ST_MISSION = 5'h01,
        ST_BROWNOUT = 5'h02,
        ST_DISPLAY = 5'h04,
        ST_SLEEP = 5'h08,
        ST_WAKING = 5'h10
    } mode_t;

endpackage

/* hw/wake_timer_if.sv */
// Signals between the mode controller and the wake interval timer core.
`timescale 1ns/10ps
interface wake_timer_if;
    logic tick;
    logic arm;
    logic interval_unit_select;
    logic [2:0] interval_count_field;
    logic start;
    logic clear;
    logic armed;
    logic counting;
    logic expired;

    modport timer (
        input tick, arm, interval_unit_select, interval_count_field,
        input start, clear,
        output armed, counting, expired
    );
    modport ctrl (
        output tick, arm, interval_unit_select, interval_count_field,
        output start, clear,
        input armed, counting, expired
    );
endinterface

/* hw/wake_interval_timer.sv */
// Wake interval timer core counting crystal ticks in selectable units.
`timescale 1ns/10ps
module wake_interval_timer #(
    parameter int unsigned UNIT_SHORT_TICKS =
        wake_timer_pkg::UNIT_SHORT_TICKS,
    parameter int unsigned UNIT_LONG_TICKS =
        wake_timer_pkg::UNIT_LONG_TICKS
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Control side
    wake_timer_if.timer t
);
    localparam logic [20:0] SHORT_LAST = 21'(UNIT_SHORT_TICKS - 1);
    localparam logic [20:0] LONG_LAST = 21'(UNIT_LONG_TICKS - 1);

    logic long_unit;
    logic [20:0] unit_cnt;
    logic [2:0] periods_left;
    logic [20:0] unit_last;

    assign unit_last = long_unit ? LONG_LAST : SHORT_LAST;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            t.armed <= 1'b0;
            t.counting <= 1'b0;
            t.expired <= 1'b0;
            long_unit <= 1'b0;
            unit_cnt <= 21'h000000;
            periods_left <= 3'h0;
        end else begin
            t.expired <= 1'b0;
            if (t.clear) begin
                t.armed <= 1'b0;
                t.counting <= 1'b0;
                unit_cnt <= 21'h000000;
                periods_left <= 3'h0;
            end else if (t.arm) begin
                t.armed <= 1'b1;
                t.counting <= 1'b0;
                unit_cnt <= 21'h000000;
                long_unit <= t.interval_unit_select;
                periods_left <= (t.interval_count_field == 3'h0) ?
                    3'h1 : t.interval_count_field;
            end else if (t.start && t.armed) begin
                t.counting <= 1'b1;
            end else if (t.counting && t.tick) begin
                if (unit_cnt == unit_last) begin
                    unit_cnt <= 21'h000000;
                    periods_left <= periods_left - 3'h1;
                    if (periods_left == 3'h1) begin
                        t.counting <= 1'b0;
                        t.expired <= 1'b1;
                    end
                end else begin
                    unit_cnt <= unit_cnt + 21'h000001;
                end
            end
        end
    end
endmodule

/* hw/battery_mode_wake_timer.sv */
// Battery-mode wake controller with wake timer and Avalon-MM registers.
//
// Summary of operation
// - In sleep or display-only mode, wake stays low until expiry, a button press or power return.
// - On expiry wake rises; processor runs within three crystal cycles.
// - A timer-caused wake sets the timer wake status flag.
// - Counting starts when the chip enters a low-power mode.
// - Unit select: one minute when 1, 2.5 seconds when 0.
// - Three-bit count field gives one to seven units.
// - Arming presets the timer; a mode request starts it.
// - Waking clears and disarms; firmware rearms each time.
// - A timer wake brings the chip up in brownout mode.
// - Low power ends only on power, timer expiry or button.
`timescale 1ns/10ps
module battery_mode_wake_timer #(
    parameter int unsigned UNIT_SHORT_TICKS =
        wake_timer_pkg::UNIT_SHORT_TICKS,
    parameter int unsigned UNIT_LONG_TICKS =
        wake_timer_pkg::UNIT_LONG_TICKS
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Wake sources
    input wire logic system_power_ok,
    input wire logic pushbutton_event,
    // Mode and wake outputs
    output logic wake,
    output logic cpu_run,
    output logic mission_mode,
    output logic brownout_mode,
    output logic display_only_mode,
    output logic sleep_mode,
    // Interrupt
    output logic irq
);
    wake_timer_if tif ();

    wake_timer_pkg::mode_t state;
    wake_timer_pkg::mode_t next_state;

    logic [25:0] xtal_acc;
    logic xtal_tick;
    logic interval_unit_select;
    logic [2:0] interval_count_field;
    logic arm_pulse;
    logic sleep_request;
    logic display_only_request;
    logic [1:0] start_ticks;
    logic [2:0] status;
    logic [2:0] mask;
    logic [2:0] ev_set;
    logic [2:0] ev_clr;
    logic timer_wake_event;
    logic button_wake;
    logic power_return;
    logic low_power;
    logic pb_prev;
    logic pb_rise;
    logic wr_hit;
    logic [31:0] next_readdata;
    logic [2:0] next_status;
    logic [2:0] next_mask;

    wake_interval_timer #(
        .UNIT_SHORT_TICKS(UNIT_SHORT_TICKS),
        .UNIT_LONG_TICKS(UNIT_LONG_TICKS)
    ) u_timer (
        .clk_sys(clk_sys),
        .rst(rst),
        .t(tif.timer)
    );

    // crystal rate enable
    // A phase accumulator gives the exact mean crystal rate from 40 MHz;
    // single ticks jitter by one system cycle, far below a count unit.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            xtal_acc <= 26'h0000000;
            xtal_tick <= 1'b0;
        end else if (xtal_acc >= wake_timer_pkg::ACC_WRAP -
                wake_timer_pkg::ACC_STEP) begin
            xtal_acc <= xtal_acc + wake_timer_pkg::ACC_STEP -
                wake_timer_pkg::ACC_WRAP;
            xtal_tick <= 1'b1;
        end else begin
            xtal_acc <= xtal_acc + wake_timer_pkg::ACC_STEP;
            xtal_tick <= 1'b0;
        end
    end

    assign low_power = (state == wake_timer_pkg::ST_DISPLAY) ||
        (state == wake_timer_pkg::ST_SLEEP);
    assign timer_wake_event = low_power && tif.expired &&
        !system_power_ok;
    // Only the rising edge of the button counts, so a press still held
    // when firmware goes back to low power does not wake it at once.
    assign pb_rise = pushbutton_event && !pb_prev;
    assign button_wake = low_power && pb_rise &&
        !system_power_ok && !tif.expired;
    // Power return is flagged on any entry to mission, from brownout too.
    assign power_return = (state != wake_timer_pkg::ST_MISSION) &&
        (next_state == wake_timer_pkg::ST_MISSION);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pb_prev <= 1'b0;
        end else begin
            pb_prev <= pushbutton_event;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            wake_timer_pkg::ST_MISSION: begin
                if (!system_power_ok) begin
                    next_state = wake_timer_pkg::ST_BROWNOUT;
                end
            end
            wake_timer_pkg::ST_BROWNOUT: begin
                if (system_power_ok) begin
                    next_state = wake_timer_pkg::ST_MISSION;
                end else if (display_only_request) begin
                    next_state = wake_timer_pkg::ST_DISPLAY;
                end else if (sleep_request) begin
                    next_state = wake_timer_pkg::ST_SLEEP;
                end
            end
            wake_timer_pkg::ST_DISPLAY,
            wake_timer_pkg::ST_SLEEP: begin
                if (system_power_ok) begin
                    next_state = wake_timer_pkg::ST_MISSION;
                end else if (timer_wake_event || button_wake) begin
                    next_state = wake_timer_pkg::ST_WAKING;
                end
            end
            wake_timer_pkg::ST_WAKING: begin
                if (system_power_ok) begin
                    next_state = wake_timer_pkg::ST_MISSION;
                end else if (start_ticks == wake_timer_pkg::START_TICKS) begin
                    next_state = wake_timer_pkg::ST_BROWNOUT;
                end
            end
            default: begin
                next_state = wake_timer_pkg::ST_MISSION;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= wake_timer_pkg::ST_MISSION;
        end else begin
            state <= next_state;
        end
    end

    // bounded start delay
    // Crystal ticks are counted from the wake rise; the processor is
    // released on the second one, inside the three-cycle limit.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            start_ticks <= 2'h0;
        end else if (state != wake_timer_pkg::ST_WAKING) begin
            start_ticks <= 2'h0;
        end else if (xtal_tick) begin
            start_ticks <= start_ticks + 2'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wake <= 1'b1;
            cpu_run <= 1'b1;
            mission_mode <= 1'b1;
            brownout_mode <= 1'b0;
            display_only_mode <= 1'b0;
            sleep_mode <= 1'b0;
        end else begin
            wake <= (next_state != wake_timer_pkg::ST_DISPLAY) &&
                (next_state != wake_timer_pkg::ST_SLEEP);
            cpu_run <= (next_state == wake_timer_pkg::ST_MISSION) ||
                (next_state == wake_timer_pkg::ST_BROWNOUT);
            mission_mode <= next_state == wake_timer_pkg::ST_MISSION;
            brownout_mode <= next_state == wake_timer_pkg::ST_BROWNOUT;
            display_only_mode <= next_state == wake_timer_pkg::ST_DISPLAY;
            sleep_mode <= next_state == wake_timer_pkg::ST_SLEEP;
        end
    end

    // Timer core hookup.
    assign tif.tick = xtal_tick;
    assign tif.arm = arm_pulse;
    assign tif.interval_unit_select = interval_unit_select;
    assign tif.interval_count_field = interval_count_field;
    assign tif.start = (state == wake_timer_pkg::ST_BROWNOUT) &&
        ((next_state == wake_timer_pkg::ST_DISPLAY) ||
        (next_state == wake_timer_pkg::ST_SLEEP));
    // disarm on every wake
    // Clearing on the way out of low power, rather than while running,
    // lets firmware arm from brownout before it asks for low power.
    assign tif.clear = low_power && !(next_state == state);

    // Avalon-MM slave: one wait cycle, then the request is answered.
    // Read data is registered in the wait cycle, which keeps the decode
    // off the bus output path at the cost of one cycle per access.
    assign wr_hit = avs_write && !avs_waitrequest && avs_byteenable[0];

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) &&
                avs_waitrequest);
        end
    end

    always_comb begin
        next_readdata = 32'h00000000;
        case (avs_address)
            wake_timer_pkg::OFS_CTRL: begin
                next_readdata[wake_timer_pkg::CTRL_ARM] = tif.armed;
                next_readdata[wake_timer_pkg::CTRL_UNIT] =
                    interval_unit_select;
                next_readdata[wake_timer_pkg::CTRL_CNT_LO +:
                    wake_timer_pkg::CNT_W] = interval_count_field;
                next_readdata[wake_timer_pkg::CTRL_RUN] = tif.counting;
            end
            wake_timer_pkg::OFS_MODE_REQ: begin
                next_readdata[wake_timer_pkg::REQ_SLEEP] = sleep_request;
                next_readdata[wake_timer_pkg::REQ_DISPLAY] =
                    display_only_request;
            end
            wake_timer_pkg::OFS_STATUS: begin
                next_readdata[wake_timer_pkg::EV_W-1:0] = status;
            end
            wake_timer_pkg::OFS_MASK: begin
                next_readdata[wake_timer_pkg::EV_W-1:0] = mask;
            end
            wake_timer_pkg::OFS_STATE: begin
                next_readdata[4:0] = state;
            end
            default: begin
                next_readdata = 32'h00000000;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= next_readdata;
        end
    end

    // arm loads settings
    // Settings and the arm pulse share one write, so the preset always
    // sees the values written alongside it.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            interval_unit_select <= 1'b0;
            interval_count_field <= 3'h1;
            arm_pulse <= 1'b0;
        end else begin
            arm_pulse <= 1'b0;
            if (wr_hit && avs_address == wake_timer_pkg::OFS_CTRL) begin
                interval_unit_select <=
                    avs_writedata[wake_timer_pkg::CTRL_UNIT];
                interval_count_field <= avs_writedata[
                    wake_timer_pkg::CTRL_CNT_LO +: wake_timer_pkg::CNT_W];
                arm_pulse <= avs_writedata[wake_timer_pkg::CTRL_ARM];
            end
        end
    end

    // Mode requests act only from brownout and are dropped once taken,
    // so a stale request cannot send the chip back to low power.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sleep_request <= 1'b0;
            display_only_request <= 1'b0;
        end else if (state != wake_timer_pkg::ST_BROWNOUT ||
                next_state != state) begin
            sleep_request <= 1'b0;
            display_only_request <= 1'b0;
        end else if (wr_hit &&
                avs_address == wake_timer_pkg::OFS_MODE_REQ) begin
            sleep_request <= avs_writedata[wake_timer_pkg::REQ_SLEEP];
            display_only_request <=
                avs_writedata[wake_timer_pkg::REQ_DISPLAY];
        end
    end

    assign ev_set = {power_return, button_wake, timer_wake_event};
    assign ev_clr = (wr_hit && avs_address == wake_timer_pkg::OFS_STATUS) ?
        avs_writedata[wake_timer_pkg::EV_W-1:0] : wake_timer_pkg::EV_RESET;

    // A set in the same cycle as a write-one clear wins.
    assign next_status = (status & ~ev_clr) | ev_set;
    assign next_mask = (wr_hit &&
        avs_address == wake_timer_pkg::OFS_MASK) ?
        avs_writedata[wake_timer_pkg::EV_W-1:0] : mask;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            status <= wake_timer_pkg::EV_RESET;
        end else begin
            status <= next_status;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mask <= wake_timer_pkg::EV_RESET;
        end else begin
            mask <= next_mask;
        end
    end

    // The interrupt follows the next status and mask, so a mask write
    // shows on it in the same cycle as in the mask register.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_status & next_mask);
        end
    end
endmodule

/* dv/battery_mode_wake_timer_checker.sv */
// Port-level assertions for the battery-mode wake timer.
`timescale 1ns/10ps
module battery_mode_wake_timer_checker #(
    parameter int unsigned UNIT_SHORT_TICKS = 4,
    parameter int unsigned UNIT_LONG_TICKS = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Bus handshake
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    // Wake sources and outputs
    input wire logic system_power_ok,
    input wire logic wake,
    input wire logic cpu_run,
    input wire logic mission_mode,
    input wire logic brownout_mode,
    input wire logic display_only_mode,
    input wire logic sleep_mode
);
    // Three crystal cycles at 40 MHz, rounded up.
    localparam int START_MAX = 3663;

    // Cycles since wake rose with the processor still held; it saturates
    // so that a start that never comes keeps the assertion firing.
    logic [11:0] start_wait;

    always_ff @(posedge clk_sys) begin
        if (rst || !wake || cpu_run) begin
            start_wait <= 12'h000;
        end else if (start_wait != 12'hFFF) begin
            start_wait <= start_wait + 12'h001;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    a_wake_low_lp: assert property (
        (sleep_mode || display_only_mode) |-> !wake)
        else $error("wake high in a low-power mode");
    a_cpu_held_reset: assert property (
        !wake |-> !cpu_run)
        else $error("processor running while wake is low");
    a_entry_holds_cpu: assert property (
        $rose(sleep_mode) || $rose(display_only_mode) |-> !wake && !cpu_run)
        else $error("low-power entry left the processor running");
    a_start_bound: assert property (
        start_wait < START_MAX)
        else $error("processor did not start within three crystal cycles");
    a_wake_brownout: assert property (
        $rose(cpu_run) && !system_power_ok |-> brownout_mode && !mission_mode)
        else $error("battery wake not in brownout mode");
    a_mission_power: assert property (
        $rose(mission_mode) |-> system_power_ok)
        else $error("mission mode entered without system power");
    a_modes_onehot: assert property (
        $onehot0({mission_mode, brownout_mode, display_only_mode, sleep_mode}))
        else $error("more than one mode output high");
    a_wait_one: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer not one cycle after request");
    a_wait_pulse: assert property (
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
endmodule

bind battery_mode_wake_timer battery_mode_wake_timer_checker #(
    .UNIT_SHORT_TICKS(UNIT_SHORT_TICKS),
    .UNIT_LONG_TICKS(UNIT_LONG_TICKS)
) chk_u (
    .clk_sys(clk_sys),
    .rst(rst),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest),
    .system_power_ok(system_power_ok),
    .wake(wake),
    .cpu_run(cpu_run),
    .mission_mode(mission_mode),
    .brownout_mode(brownout_mode),
    .display_only_mode(display_only_mode),
    .sleep_mode(sleep_mode)
);

/* dv/battery_mode_wake_timer_tb.sv */
// Register-level testbench for the battery-mode wake timer.
`timescale 1ns/10ps
module battery_mode_wake_timer_tb;
    // System clock cycles per crystal tick, rounded up.
    localparam int TICK = 1221;
    localparam int LIMIT = 95000;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic system_power_ok = 1'b0;
    logic pushbutton_event = 1'b0;
    logic wake;
    logic cpu_run;
    logic mission_mode;
    logic brownout_mode;
    logic display_only_mode;
    logic sleep_mode;
    logic irq;
    logic [31:0] rdata;
    logic [4:0] addr_tab [5] = '{5'h00, 5'h08, 5'h0C, 5'h10, 5'h14};
    logic [31:0] exp_tab [5] = '{32'h4, 32'h0, 32'h0, 32'h2, 32'h0};
    int err_count = 0;
    int check_count = 0;
    int cycles = 0;
    int n;

    always #12.5 clk_sys = ~clk_sys;

    battery_mode_wake_timer #(
        .UNIT_SHORT_TICKS(4),
        .UNIT_LONG_TICKS(8)
    ) dut_u (
        .clk_sys(clk_sys),
        .rst(rst),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .system_power_ok(system_power_ok),
        .pushbutton_event(pushbutton_event),
        .wake(wake),
        .cpu_run(cpu_run),
        .mission_mode(mission_mode),
        .brownout_mode(brownout_mode),
        .display_only_mode(display_only_mode),
        .sleep_mode(sleep_mode),
        .irq(irq)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Holds the request until waitrequest is sampled low, then one idle edge.
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] d, input logic [3:0] be);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= ~wr;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk_sys);
        end
        rdata = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic reg_write(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask

    task automatic reg_read(input logic [4:0] a);
        bus(1'b0, a, 32'h0, 4'hF);
    endtask

    // Arms, waits, enters low power and times the wake and the start.
    task automatic timed_wake(input logic [31:0] ctrl, input logic [1:0] req,
                              input int ticks);
        reg_write(wake_timer_pkg::OFS_CTRL, ctrl);
        reg_read(wake_timer_pkg::OFS_CTRL);
        check(rdata, ctrl);
        // The lead time also shows that counting does not start at arming.
        repeat (4 * TICK) @(posedge clk_sys);
        reg_write(wake_timer_pkg::OFS_MODE_REQ, 32'(req));
        n = 2;
        repeat (2) @(posedge clk_sys);
        check(32'({display_only_mode, sleep_mode, wake, cpu_run}),
              32'({req, 2'b00}));
        while (wake !== 1'b1) begin
            @(posedge clk_sys);
            n++;
        end
        check(32'(n >= (ticks - 1) * 1220 && n <= (ticks + 1) * TICK),
              32'h1);
        n = 0;
        while (cpu_run !== 1'b1) begin
            @(posedge clk_sys);
            n++;
        end
        check(32'(n <= 3 * TICK), 32'h1);
        check(32'({brownout_mode, mission_mode}), 32'h2);
        check(32'(irq), 32'h1);
        reg_read(wake_timer_pkg::OFS_STATUS);
        check(rdata, 32'h1);
        reg_read(wake_timer_pkg::OFS_CTRL);
        check(32'(rdata[0]), 32'h0);
        reg_write(wake_timer_pkg::OFS_STATUS, 32'h1);
        check(32'(irq), 32'h0);
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == LIMIT) begin
            err_count++;
            print_verdict();
        end
    end

    initial begin
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        check(32'({mission_mode, brownout_mode, wake, cpu_run, irq}), 32'h0E);
        for (int i = 0; i < 5; i++) begin
            reg_read(addr_tab[i]);
            check(rdata, exp_tab[i]);
        end
        bus(1'b1, wake_timer_pkg::OFS_MASK, 32'h7, 4'h0);
        reg_read(wake_timer_pkg::OFS_MASK);
        check(rdata, 32'h0);
        reg_write(wake_timer_pkg::OFS_MASK, 32'h1);
        timed_wake(32'h09, 2'b01, 8);
        timed_wake(32'h07, 2'b10, 8);
        timed_wake(32'h0D, 2'b01, 12);
        // Unarmed sleep must outlast every interval tested above.
        reg_write(wake_timer_pkg::OFS_MODE_REQ, 32'h1);
        repeat (16 * TICK) @(posedge clk_sys);
        check(32'({sleep_mode, wake}), 32'h2);
        pushbutton_event <= 1'b1;
        @(posedge clk_sys);
        pushbutton_event <= 1'b0;
        while (cpu_run !== 1'b1) begin
            @(posedge clk_sys);
        end
        reg_read(wake_timer_pkg::OFS_STATUS);
        check(rdata, 32'h2);
        check(32'(irq), 32'h0);
        reg_write(wake_timer_pkg::OFS_STATUS, 32'h2);
        system_power_ok <= 1'b1;
        while (mission_mode !== 1'b1) begin
            @(posedge clk_sys);
        end
        reg_read(wake_timer_pkg::OFS_STATUS);
        check(rdata, 32'h4);
        reg_write(wake_timer_pkg::OFS_MASK, 32'h5);
        check(32'(irq), 32'h1);
        reg_write(wake_timer_pkg::OFS_STATUS, 32'h4);
        check(32'(irq), 32'h0);
        // Low-power requests are refused outside brownout.
        reg_write(wake_timer_pkg::OFS_MODE_REQ, 32'h1);
        repeat (4) @(posedge clk_sys);
        check(32'({mission_mode, sleep_mode, wake}), 32'h5);
        reg_read(wake_timer_pkg::OFS_MODE_REQ);
        check(rdata, 32'h0);
        print_verdict();
    end
endmodule
